// file: rlc_pkg.sv
// Package for the reference ladder control block: register map, field layout, reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package rlc_pkg;

    // Register byte offsets.
    localparam logic [3:0] CTRL0_OFFSET = 4'h0;
    localparam logic [3:0] CTRL1_OFFSET = 4'h4;

    // Control register 0 field positions.
    localparam int CTRL0_ENABLE_BIT = 7;
    localparam int CTRL0_LPS_BIT    = 6;
    localparam int CTRL0_PINOE_BIT  = 5;
    localparam int CTRL0_PSS_LSB    = 2;
    localparam int CTRL0_NSS_BIT    = 0;

    // Writable masks; every other bit is unimplemented and reads zero.
    localparam logic [7:0] CTRL0_MASK  = 8'hed;
    localparam logic [7:0] CTRL1_MASK  = 8'h1f;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;

    // Positive source choices.
    localparam logic [1:0] PSS_SUPPLY   = 2'h0;
    localparam logic [1:0] PSS_EXTERNAL = 2'h1;
    localparam logic [1:0] PSS_FIXED    = 2'h2;
    localparam logic [1:0] PSS_RESERVED = 2'h3;

    // Static levels handed to the analog ladder.
    typedef struct packed {
        logic       conv_enable;
        logic       low_power_source_sel;
        logic       pin_output_enable;
        logic [1:0] positive_source_sel;
        logic       negative_source_sel;
        logic [4:0] output_code;
    } rlc_ladder_t;

    // Decoded Wishbone request.
    typedef struct packed {
        logic       hit0;
        logic       hit1;
        logic       wr;
        logic [7:0] data;
    } rlc_req_t;

endpackage : rlc_pkg

// file: rlc_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module rlc_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Data
    input  wire logic din,
    output var  logic dout
);
    logic s1;
    logic s2;
    logic s3;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule : rlc_sync
`default_nettype wire

// file: rlc_wb_slave.sv
// Classic Wishbone slave front end: decodes two byte registers, acks one cycle after strobe.
// Assumes the master holds the request until ack and drops stb afterwards.
`timescale 1ns/1ps
`default_nettype none
module rlc_wb_slave (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Wishbone
    input  wire logic              cyc,
    input  wire logic              stb,
    input  wire logic              we,
    input  wire logic [3:0]        adr,
    input  wire logic [3:0]        sel,
    input  wire logic [7:0]        dat_lo,
    output var  logic              ack,
    // Decoded request, valid in the ack cycle
    output var  rlc_pkg::rlc_req_t req
);
    logic ack_hold;

    // The outer ack shows one cycle after ack, while the master still holds its request;
    // ack_hold stops that standing request from being taken a second time.
    wire req_on = cyc && stb && !ack && !ack_hold;
    wire hit0   = adr == rlc_pkg::CTRL0_OFFSET;
    wire hit1   = adr == rlc_pkg::CTRL1_OFFSET;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack      <= 1'b0;
            ack_hold <= 1'b0;
        end else begin
            ack      <= req_on;
            ack_hold <= ack;
        end
    end

    // Writes need byte lane 0; an unmapped address is acked and reads zero.
    assign req.hit0 = ack && hit0;
    assign req.hit1 = ack && hit1;
    assign req.wr   = ack && we && sel[0];
    assign req.data = dat_lo;
endmodule : rlc_wb_slave
`default_nettype wire

// file: rlc_top.sv
// Reference ladder control: two byte control registers and reference pin routing.
// Assumes classic Wishbone on SYS_CLK; the ladder itself is analog and lies outside.
//
// How it works
// R01: Control 0 bit 7 enables the converter when one.
// R02: Control 0 bit 6 selects which source stays connected in low power.
// R03: Control 0 bit 5 routes the ladder output to the reference pin.
// R04: Bits 3-2 choose supply, external or fixed reference; code three is reserved.
// R05: Bit 0 chooses external negative reference when one, ground when zero.
// R06: Control 1 bits 4-0 hold the ladder output code over thirty-two steps.
// R07: The output code is right-justified in its register.
// R08: Unimplemented bits ignore writes and read as zero.
// R09: Software clamps high with enable off, low power one, code all ones.
// R10: Software clamps low with enable off, low power zero, code zero.
// R11: Routing to the pin disables its digital driver and input detector.
// R12: Reading the pin while it carries the reference returns zero.
// R13: Waking from sleep leaves control register 0 unchanged.
// R14: Reset disables the converter, frees the pin and clears all fields.
// R15: Software should disable the reference before sleep.
// R16: Ladder output is offered to comparator, converter channel and pin.
// R17: Controls reach the ladder as registered levels one edge after a write.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module rlc_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output var  logic [31:0] WB_DAT_O,
    output var  logic        WB_ACK_O,
    // Ladder controls
    output var  logic        CONV_ENABLE,
    output var  logic        LOW_POWER_SOURCE_SEL,
    output var  logic [1:0]  POSITIVE_SOURCE_SEL,
    output var  logic        NEGATIVE_SOURCE_SEL,
    output var  logic [4:0]  OUTPUT_CODE,
    // Analog routing of the ladder output
    output var  logic        ROUTE_TO_COMPARATOR,
    output var  logic        ROUTE_TO_ADC,
    output var  logic        ROUTE_TO_PIN,
    // Reference pin digital path
    input  wire logic        PIN_OUT_DATA,
    input  wire logic        PIN_OUT_DRIVE,
    input  wire logic        REFERENCE_OUT_PIN_I,
    output var  logic        REFERENCE_OUT_PIN_O,
    output var  logic        REFERENCE_OUT_PIN_OE,
    output var  logic        PIN_INPUT_BUF_EN,
    output var  logic        PIN_READ_DATA
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end.

    rlc_pkg::rlc_req_t req;
    logic              ack;

    rlc_wb_slave u_bus (
        .clk    (SYS_CLK),
        .rst_n  (RST_N),
        .cyc    (WB_CYC_I),
        .stb    (WB_STB_I),
        .we     (WB_WE_I),
        .adr    (WB_ADR_I),
        .sel    (WB_SEL_I),
        .dat_lo (WB_DAT_I[7:0]),
        .ack    (ack),
        .req    (req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.

    // Unimplemented bits are dropped on the way in, so they can never read back as one.
    function automatic logic [7:0] implemented_bits(
        input logic [7:0] data,
        input logic [7:0] mask
    );
        implemented_bits = data & mask;
    endfunction : implemented_bits

    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    wire        wr0     = req.wr && req.hit0;
    wire        wr1     = req.wr && req.hit1;
    wire  [7:0] next_c0 = implemented_bits(req.data, rlc_pkg::CTRL0_MASK);   // [R08]
    wire  [7:0] next_c1 = implemented_bits(req.data, rlc_pkg::CTRL1_MASK);   // [R07] [R08]

    // Sleep and wake never touch these; only reset and writes change them.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl0 <= rlc_pkg::CTRL0_RESET;                   // [R14]
            ctrl1 <= rlc_pkg::CTRL1_RESET;                   // [R14]
        end else begin
            if (wr0) begin
                ctrl0 <= next_c0;                            // [R13]
            end
            if (wr1) begin
                ctrl1 <= next_c1;
            end
        end
    end

    wire [7:0] rd_byte = req.hit0 ? ctrl0 : (req.hit1 ? ctrl1 : 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Decoded ladder levels.

    rlc_pkg::rlc_ladder_t lad;
    assign lad.conv_enable          = ctrl0[rlc_pkg::CTRL0_ENABLE_BIT];          // [R01]
    assign lad.low_power_source_sel = ctrl0[rlc_pkg::CTRL0_LPS_BIT];             // [R02]
    assign lad.pin_output_enable    = ctrl0[rlc_pkg::CTRL0_PINOE_BIT];           // [R03]
    assign lad.positive_source_sel  = ctrl0[rlc_pkg::CTRL0_PSS_LSB +: 2];        // [R04]
    assign lad.negative_source_sel  = ctrl0[rlc_pkg::CTRL0_NSS_BIT];             // [R05]
    assign lad.output_code          = ctrl1[4:0];                                // [R06]

    // The reserved source code is passed through unchanged; software must avoid it.
    wire pss_reserved = lad.positive_source_sel == rlc_pkg::PSS_RESERVED;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser.

    logic pin_in_sync;

    rlc_sync u_pin_sync (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .din   (REFERENCE_OUT_PIN_I),
        .dout  (pin_in_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs, one edge behind the register.

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O             <= 1'b0;
            WB_DAT_O             <= 32'h0000_0000;
            CONV_ENABLE          <= 1'b0;
            LOW_POWER_SOURCE_SEL <= 1'b0;
            POSITIVE_SOURCE_SEL  <= 2'h0;
            NEGATIVE_SOURCE_SEL  <= 1'b0;
            OUTPUT_CODE          <= 5'h00;
            ROUTE_TO_COMPARATOR  <= 1'b0;
            ROUTE_TO_ADC         <= 1'b0;
            ROUTE_TO_PIN         <= 1'b0;
            REFERENCE_OUT_PIN_O  <= 1'b0;
            REFERENCE_OUT_PIN_OE <= 1'b0;
            PIN_INPUT_BUF_EN     <= 1'b0;
            PIN_READ_DATA        <= 1'b0;
        end else begin
            WB_ACK_O             <= ack;
            WB_DAT_O             <= {24'h00_0000, rd_byte};
            CONV_ENABLE          <= lad.conv_enable;                      // [R17]
            LOW_POWER_SOURCE_SEL <= lad.low_power_source_sel;             // [R17]
            POSITIVE_SOURCE_SEL  <= lad.positive_source_sel;              // [R17]
            NEGATIVE_SOURCE_SEL  <= lad.negative_source_sel;              // [R17]
            OUTPUT_CODE          <= lad.output_code;                      // [R17]
            ROUTE_TO_COMPARATOR  <= 1'b1;                                 // [R16]
            ROUTE_TO_ADC         <= 1'b1;                                 // [R16]
            ROUTE_TO_PIN         <= lad.pin_output_enable;                // [R16] [R03]
            REFERENCE_OUT_PIN_O  <= PIN_OUT_DATA && !lad.pin_output_enable;
            REFERENCE_OUT_PIN_OE <= PIN_OUT_DRIVE && !lad.pin_output_enable;  // [R11]
            PIN_INPUT_BUF_EN     <= !lad.pin_output_enable;               // [R11]
            PIN_READ_DATA        <= pin_in_sync && !lad.pin_output_enable;    // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_ctrl0_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R01]
        wr0 |=> ##1 (CONV_ENABLE == $past(next_c0[7], 2)))
        else $error("enable output does not follow control 0 write");

    a_lps_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R02]
        wr0 |=> ##1 (LOW_POWER_SOURCE_SEL == $past(next_c0[6], 2)))
        else $error("low power select does not follow write");

    a_pin_route: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R03]
        ROUTE_TO_PIN == $past(ctrl0[5]))
        else $error("pin routing does not follow control bit");

    a_pss_field: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R04]
        wr0 |=> ##1 (POSITIVE_SOURCE_SEL == $past(WB_DAT_I[3:2], 2)))
        else $error("positive source select wrong");

    a_nss_field: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R05]
        wr0 |=> ##1 (NEGATIVE_SOURCE_SEL == $past(WB_DAT_I[0], 2)))
        else $error("negative source select wrong");

    a_code_write: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R06]
        wr1 |=> ##1 (OUTPUT_CODE == $past(WB_DAT_I[4:0], 2)))
        else $error("output code does not follow write");

    a_unimpl_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R08]
        WB_ACK_O |-> (WB_DAT_O[31:8] == 24'h0 && (WB_DAT_O[7:0] & 8'h12) == 8'h00
                      || WB_DAT_O[7:5] == 3'h0 && $past(req.hit1)))
        else $error("unimplemented bits read nonzero");

    a_pin_driver_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R11]
        ROUTE_TO_PIN |-> (!REFERENCE_OUT_PIN_OE && !PIN_INPUT_BUF_EN))
        else $error("digital pin path active while routed");

    a_pin_read_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R12]
        ROUTE_TO_PIN |-> !PIN_READ_DATA)
        else $error("pin read nonzero while routed");

    a_ack_single: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    ////////////////////////////////////////////////////////////////////////////
    // Register and pin path checks.

    a_ctrl0_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R13]
        !wr0 |=> $stable(ctrl0))
        else $error("control 0 changed without a write");

    a_ctrl1_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
        !wr1 |=> $stable(ctrl1))
        else $error("control 1 changed without a write");

    a_unimpl_store: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R08]
        ctrl0[4] == 1'b0 && ctrl0[1] == 1'b0 && ctrl1[7:5] == 3'h0)
        else $error("unimplemented bit stored as one");

    a_levels_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
        {CONV_ENABLE, LOW_POWER_SOURCE_SEL, POSITIVE_SOURCE_SEL, NEGATIVE_SOURCE_SEL}
            == $past({ctrl0[7], ctrl0[6], ctrl0[3:2], ctrl0[0]}))
        else $error("ladder levels do not follow control 0");

    a_code_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R07]
        OUTPUT_CODE == $past(ctrl1[4:0]))
        else $error("output code does not follow control 1");

    a_read_ctrl0: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R08]
        WB_ACK_O && $past(req.hit0) |-> WB_DAT_O == {24'h00_0000, $past(ctrl0)})
        else $error("control 0 read data wrong");

    a_read_ctrl1: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R07]
        WB_ACK_O && $past(req.hit1) |-> WB_DAT_O == {24'h00_0000, $past(ctrl1)})
        else $error("control 1 read data wrong");

    a_pin_data_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R11]
        ROUTE_TO_PIN |-> !REFERENCE_OUT_PIN_O)
        else $error("pin data driven while routed");

    a_pin_oe_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R11]
        !ROUTE_TO_PIN |-> REFERENCE_OUT_PIN_OE == $past(PIN_OUT_DRIVE))
        else $error("pin driver does not follow port logic");

    a_pin_input_live: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R12]
        !ROUTE_TO_PIN |-> PIN_READ_DATA == $past(pin_in_sync))
        else $error("pin read does not follow the pin");

    a_analog_offer: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R16]
        $past(RST_N) |-> ROUTE_TO_COMPARATOR && ROUTE_TO_ADC)
        else $error("ladder output not offered to comparator and converter");

    // Catches a slave that answers one request twice or after the master has let go.
    a_ack_in_cycle: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
        WB_ACK_O |-> WB_CYC_I && WB_STB_I)
        else $error("ack given outside a standing request");

    ////////////////////////////////////////////////////////////////////////////
    // Static level check.

    // Cycles since the last register write, saturating; the levels may move only in the
    // two cycles right after a write, never while software is quiet.
    logic [3:0] quiet_cycles;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            quiet_cycles <= 4'h0;
        end else if (wr0 || wr1) begin
            quiet_cycles <= 4'h0;
        end else if (quiet_cycles != 4'hf) begin
            quiet_cycles <= quiet_cycles + 4'h1;
        end
    end

    a_levels_static: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R17]
        quiet_cycles >= 4'h2 |-> $stable({CONV_ENABLE, LOW_POWER_SOURCE_SEL, ROUTE_TO_PIN,
            POSITIVE_SOURCE_SEL, NEGATIVE_SOURCE_SEL, OUTPUT_CODE}))
        else $error("ladder levels moved without a write");

    c_write0: cover property (@(posedge SYS_CLK) disable iff (!RST_N) wr0);
    c_write1: cover property (@(posedge SYS_CLK) disable iff (!RST_N) wr1);
    c_routed: cover property (@(posedge SYS_CLK) disable iff (!RST_N) ROUTE_TO_PIN);
    c_reserved: cover property (@(posedge SYS_CLK) disable iff (!RST_N) pss_reserved);
    c_clamp_high: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        !CONV_ENABLE && LOW_POWER_SOURCE_SEL && OUTPUT_CODE == 5'h1f);

endmodule : rlc_top
`default_nettype wire

// file: rlc_tb.sv
// Self-checking bench for the reference ladder control block.
// Assumes rlc_pkg and rlc_top are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk;
    logic        rst_n;
    logic        cyc, stb, we;
    logic [3:0]  adr, sel;
    logic [31:0] dat_i, dat_o;
    logic        ack, en, lps, nss, r_cmp, r_adc, r_pin;
    logic [1:0]  pss;
    logic [4:0]  code;
    logic        p_data, p_drive, p_in, p_o, p_oe, p_buf, p_rd;
    int          err_count = 0;
    int          checks = 0;
    wire  [7:0]  view0 = {en, lps, r_pin, 1'b0, pss, 1'b0, nss};
    wire  [7:0]  view1 = {3'h0, code};
    rlc_top u_rlc_top (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .CONV_ENABLE(en), .LOW_POWER_SOURCE_SEL(lps),
        .POSITIVE_SOURCE_SEL(pss), .NEGATIVE_SOURCE_SEL(nss), .OUTPUT_CODE(code),
        .ROUTE_TO_COMPARATOR(r_cmp), .ROUTE_TO_ADC(r_adc), .ROUTE_TO_PIN(r_pin),
        .PIN_OUT_DATA(p_data), .PIN_OUT_DRIVE(p_drive), .REFERENCE_OUT_PIN_I(p_in),
        .REFERENCE_OUT_PIN_O(p_o), .REFERENCE_OUT_PIN_OE(p_oe), .PIN_INPUT_BUF_EN(p_buf),
        .PIN_READ_DATA(p_rd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Entered just after a rising edge; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [7:0] d, output logic [31:0] rd);
        int n;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) chk({31'h0, ack}, 32'h1);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge sys_clk);
    endtask : wb
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] x;
        wb(1'b1, a, 4'h1, d, x);
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [31:0] x;
        wb(1'b0, a, 4'hf, 8'h00, x);
        chk(x, {24'h0, e});
    endtask : rdchk
    task automatic lad(input logic [7:0] e0, input logic [7:0] e1);
        chk({24'h0, view0}, {24'h0, e0});
        chk({24'h0, view1}, {24'h0, e1});
    endtask : lad
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state;
        rdchk(4'h0, 8'h00);
        rdchk(4'h4, 8'h00);
        lad(8'h00, 8'h00);
        chk({29'h0, r_cmp, r_adc, p_buf}, 32'h7);
    endtask : t_reset_state
    task automatic t_fields;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            wr(4'h0, v);
            rdchk(4'h0, v & 8'hed);
            lad(v & 8'hed, 8'h00);
        end
        for (int p = 0; p < 4; p++) begin
            wr(4'h0, {4'h0, p[1:0], 2'h0});
            chk({30'h0, pss}, p);
        end
        wr(4'h0, 8'h00);
        foreach (v[i]) begin
            wr(4'h4, 8'he0 | (8'h01 << (i % 5)));
            rdchk(4'h4, 8'h01 << (i % 5));
            chk({27'h0, code}, 32'h1 << (i % 5));
        end
    endtask : t_fields
    task automatic t_clamp;
        wr(4'h0, 8'h48);
        wr(4'h4, 8'h1f);
        lad(8'h48, 8'h1f);
        wr(4'h0, 8'h01);
        wr(4'h4, 8'h00);
        lad(8'h01, 8'h00);
        wr(4'h0, 8'h00);
        chk({31'h0, en}, 32'h0);
    endtask : t_clamp
    // The pin path runs through a synchroniser, so levels are judged after it settles.
    task automatic t_pin;
        p_drive <= 1'b1; p_data <= 1'b1; p_in <= 1'b1;
        wr(4'h0, 8'h00);
        repeat (8) @(posedge sys_clk);
        chk({28'h0, p_oe, p_o, p_buf, p_rd}, 32'hf);
        wr(4'h0, 8'h20);
        repeat (8) @(posedge sys_clk);
        chk({28'h0, p_oe, r_pin, p_buf, p_rd}, 32'h4);
        chk({31'h0, p_o}, 32'h0);
        wr(4'h0, 8'h00);
        p_drive <= 1'b0; p_in <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({30'h0, p_oe, p_rd}, 32'h0);
    endtask : t_pin
    task automatic t_refused;
        logic [31:0] x;
        wr(4'h0, 8'h44);
        wr(4'h8, 8'hff);
        rdchk(4'h8, 8'h00);
        wb(1'b1, 4'h0, 4'h0, 8'hff, x);
        rdchk(4'h0, 8'h44);
    endtask : t_refused
    task automatic t_mid_reset;
        wr(4'h0, 8'hed);
        wr(4'h4, 8'h1f);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        lad(8'h00, 8'h00);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdchk(4'h0, 8'h00);
        rdchk(4'h4, 8'h00);
    endtask : t_mid_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
        dat_i = 32'h0; p_data = 1'b0; p_drive = 1'b0; p_in = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset_state();
        t_fields();
        t_clamp();
        t_pin();
        t_refused();
        t_mid_reset();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
